// File: sram_capture_regs.svh
// Purpose: Named constants for the write-port capture block
// Assumes: Wide (x36) configuration, four 9-bit lanes
// Notes: Narrow configuration uses lanes 0 and 1 only
`ifndef SRAM_CAPTURE_REGS_SVH
`define SRAM_CAPTURE_REGS_SVH
`define DATA_W 36
`define LANE_W 9
`define LANES 4
`define ADDR_W 19
`define ADDR_W_NARROW 20
`define DATA_W_NARROW 18
`define LANES_NARROW 2
`define BEAT0 1'b0
`define BEAT1 1'b1
`endif

// File: sram_capture_pkg.sv
// Purpose: Types shared by the capture block
// Assumes: Wide configuration
// Notes: Constants live in sram_capture_regs.svh
`include "sram_capture_regs.svh"
package sram_capture_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_WR_HALF, ST_RD_HALF} phase_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`LANES-1:0] lanes_t;
endpackage : sram_capture_pkg

// File: beat_if.sv
// Purpose: Carries one captured write beat to the lane merger
// Assumes: Single clock domain
// Notes: Lane selects already converted to active-high enables
`timescale 1ns/100ps
`include "sram_capture_regs.svh"
interface beat_if;
    logic valid;
    logic [`ADDR_W:0] word_addr;
    logic [`DATA_W-1:0] data;
    logic [`LANES-1:0] lane_en;
    logic [`DATA_W-1:0] old_word;
    logic [`DATA_W-1:0] merged;
    modport src (output valid, output word_addr, output data,
        output lane_en, output old_word, input merged);
    modport dst (input valid, input word_addr, input data,
        input lane_en, input old_word, output merged);
endinterface : beat_if

// File: lane_merge.sv
// Purpose: Merges a write beat into the previous word lane by lane
// Assumes: Enables are active high
// Notes: Pure combinational
`timescale 1ns/100ps
`include "sram_capture_regs.svh"
module lane_merge (
    beat_if.dst b
);
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1)
        begin : g_lane
            // Disabled lanes keep the stored bits
            assign b.merged[g*`LANE_W +: `LANE_W] = b.lane_en[g] ?
                b.data[g*`LANE_W +: `LANE_W] :
                b.old_word[g*`LANE_W +: `LANE_W];
        end
    endgenerate
endmodule : lane_merge

// File: sync_sram_write_port_capture.sv
// Purpose: Input capture and storage of a two-beat burst SRAM
// Assumes: clk models the positive clock; the negative-clock edge is
//          modelled as the second half-cycle beat, taken on the next
//          clk edge (beat 1)
// Notes: Memory is a behavioural array; narrow mode masks upper lanes on writes only, rd_data returns all four lanes
`timescale 1ns/100ps
`include "sram_capture_regs.svh"

module sync_sram_write_port_capture (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic narrow_mode,
    input wire logic [`ADDR_W_NARROW-1:0] addr,
    input wire logic [`DATA_W-1:0] wr_data,
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic byte_lane0_write_n,
    input wire logic byte_lane1_write_n,
    input wire logic byte_lane2_write_n,
    input wire logic byte_lane3_write_n,
    output logic [`DATA_W-1:0] rd_data,
    output logic rd_data_oe,
    output logic wr_commit
);
    localparam int DEPTH = 1 << (`ADDR_W + 1);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    typedef struct packed {
        logic [`ADDR_W_NARROW-1:0] addr;
        logic [`DATA_W-1:0] data;
        logic wps_n;
        logic rps_n;
        logic [`LANES-1:0] bws_n;
        logic narrow;
    } pins_t;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        sram_capture_pkg::phase_t phase;
        logic [`ADDR_W:0] wr_base;
        logic [`ADDR_W:0] rd_base;
        logic rd_pend;
        logic [`DATA_W-1:0] rd_data;
        logic rd_oe;
        logic commit;
    } state_t;

    state_t st_q;
    state_t st_d;
    pins_t pins;

    logic [`DATA_W-1:0] mem [DEPTH];
    beat_if bi ();

    lane_merge u_merge (
        .b(bi)
    );

    // Narrow mode takes one more address bit, dropped from the index, and only two lanes
    function automatic logic [`ADDR_W:0] word_index(
        input logic [`ADDR_W_NARROW-1:0] a,
        input logic narrow,
        input logic beat
    );
        logic [`ADDR_W:0] base;
        base = narrow ? {a[`ADDR_W_NARROW-1:0]} :
            {1'b0, a[`ADDR_W-1:0]};
        word_index = {base[`ADDR_W-1:0], beat};
    endfunction : word_index

    function automatic logic [`LANES-1:0] lane_mask(
        input logic [`LANES-1:0] sel_n,
        input logic narrow
    );
        logic [`LANES-1:0] m;
        m = ~sel_n;
        if (narrow)
        begin
            m[`LANES-1:`LANES_NARROW] = '0;
        end
        lane_mask = m;
    endfunction : lane_mask

    always_comb
    begin
        pins.addr = addr;
        pins.data = wr_data;
        pins.wps_n = write_port_select_n;
        pins.rps_n = read_port_select_n;
        pins.bws_n = {byte_lane3_write_n, byte_lane2_write_n,
            byte_lane1_write_n, byte_lane0_write_n};
        pins.narrow = narrow_mode;
    end

    // ****************************************************************
    // Beat capture and read pipeline
    // ****************************************************************
    logic wr_beat;
    logic wr_beat_no;
    logic [`ADDR_W:0] wr_idx;
    logic [`ADDR_W:0] rd_idx;
    logic rd_beat;
    logic rd_beat_no;
    logic [`DATA_W-1:0] mem_rd;
    logic [`DATA_W-1:0] data_in;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.commit = 1'b0;
        wr_beat = 1'b0;
        wr_beat_no = `BEAT0;
        rd_beat = 1'b0;
        rd_beat_no = `BEAT0;
        wr_idx = '0;
        rd_idx = '0;
        data_in = st_q.s2.data;
        if (st_q.s2.narrow)
        begin
            data_in[`DATA_W-1:`DATA_W_NARROW] = '0;
        end
        // Write beat 1 belongs to the burst opened last cycle
        if (st_q.phase == sram_capture_pkg::ST_WR_HALF)
        begin
            wr_beat = 1'b1;
            wr_beat_no = `BEAT1;
            wr_idx = st_q.wr_base | {{`ADDR_W{1'b0}}, `BEAT1};
            st_d.phase = sram_capture_pkg::ST_IDLE;
            st_d.commit = 1'b1;
        end
        else
        begin
            st_d.phase = sram_capture_pkg::ST_IDLE;
            // Write starts only on a positive edge with select low
            if (!st_q.s2.wps_n)
            begin
                wr_beat = 1'b1;
                wr_beat_no = `BEAT0;
                // Write address taken with the select on this positive edge, beat 0
                wr_idx = word_index(st_q.s2.addr, st_q.s2.narrow,
                    `BEAT0);
                st_d.wr_base = wr_idx;
                st_d.phase = sram_capture_pkg::ST_WR_HALF;
            end
            // Select high: data, lanes and write address ignored
        end
        // Read: two transfers, address on the positive edge
        if (st_q.rd_pend)
        begin
            rd_beat = 1'b1;
            rd_beat_no = `BEAT1;
            rd_idx = st_q.rd_base | {{`ADDR_W{1'b0}}, `BEAT1};
            st_d.rd_pend = 1'b0;
        end
        else if (!st_q.s2.rps_n)
        begin
            rd_beat = 1'b1;
            rd_beat_no = `BEAT0;
            rd_idx = word_index(st_q.s2.addr, st_q.s2.narrow,
                `BEAT0);
            st_d.rd_base = rd_idx;
            st_d.rd_pend = 1'b1;
        end
        // Pending read finishes before the drivers release
        st_d.rd_oe = rd_beat;
        mem_rd = mem[rd_idx];
        bi.valid = wr_beat;
        bi.word_addr = wr_idx;
        bi.data = data_in;
        // Lanes and data sampled together on this beat
        bi.lane_en = wr_beat ? lane_mask(st_q.s2.bws_n,
            st_q.s2.narrow) : '0;
        bi.old_word = mem[wr_idx];
        // Bypass the beat being written to keep reads coherent
        if (rd_beat && wr_beat && rd_idx == wr_idx)
        begin
            st_d.rd_data = bi.merged;
        end
        else
        begin
            st_d.rd_data = rd_beat ? mem_rd : st_q.rd_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '{s1: '{wps_n: 1'b1, rps_n: 1'b1, bws_n: '1,
                default: '0}, s2: '{wps_n: 1'b1, rps_n: 1'b1,
                bws_n: '1, default: '0},
                phase: sram_capture_pkg::ST_IDLE, default: '0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Storage array is not reset; contents are undefined at power-up
    always_ff @(posedge clk)
    begin
        if (bi.valid)
        begin
            mem[bi.word_addr] <= bi.merged;
        end
    end

    assign rd_data = st_q.rd_data;
    assign rd_data_oe = st_q.rd_oe;
    assign wr_commit = st_q.commit;
endmodule : sync_sram_write_port_capture

// File: sram_cap_checker.sv
// Purpose: Port timing checks for the capture block
// Assumes: Requests are single-cycle select pulses
// Notes: Latencies follow the hand-over walk
`timescale 1ns/100ps
`include "sram_capture_regs.svh"
module sram_cap_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic [`DATA_W-1:0] rd_data,
    input wire logic rd_data_oe,
    input wire logic wr_commit
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_wr_latency: assert property (
        $fell(write_port_select_n) |-> ##4 wr_commit) else $error("late commit");
    chk_commit_cause: assert property (
        wr_commit |-> !$past(write_port_select_n, 4)) else $error("stray commit");
    chk_commit_pulse: assert property (
        wr_commit |=> !wr_commit) else $error("commit too long");
    chk_idle_quiet: assert property (
        write_port_select_n [*5] |-> !wr_commit) else $error("idle commit");
    chk_read_burst: assert property (
        $fell(read_port_select_n) |-> ##3 rd_data_oe [*2] ##1 !rd_data_oe)
        else $error("bad read burst");
    chk_oe_cause: assert property (
        $rose(rd_data_oe) |-> !$past(read_port_select_n, 3))
        else $error("stray read");
    chk_oe_release: assert property (
        rd_data_oe ##1 rd_data_oe |=> !rd_data_oe) else $error("oe held");
    chk_data_hold: assert property (
        $changed(rd_data) |-> rd_data_oe) else $error("rd_data moved");
    cover property (wr_commit);
    cover property ($rose(rd_data_oe));
    cover property (wr_commit ##[1:8] rd_data_oe);
endmodule : sram_cap_checker
bind sync_sram_write_port_capture sram_cap_checker u_chk (.clk(clk),
    .rst_n(rst_n), .write_port_select_n(write_port_select_n),
    .read_port_select_n(read_port_select_n), .rd_data(rd_data),
    .rd_data_oe(rd_data_oe), .wr_commit(wr_commit));

// File: mem_ctrl_model.sv
// Purpose: Memory controller driving address, data and selects
// Assumes: Drives only just after falling clock edges
// Notes: Released lines churn so stale values never match
`timescale 1ns/100ps
`include "sram_capture_regs.svh"
module mem_ctrl_model (
    input wire logic clk,
    output logic [`ADDR_W_NARROW-1:0] addr,
    output logic [`DATA_W-1:0] wr_data,
    output logic write_port_select_n,
    output logic read_port_select_n,
    output logic [`LANES-1:0] lanes_n
);
    initial
    begin
        addr = 20'h00000;
        wr_data = 36'h000000000;
        write_port_select_n = 1'b1;
        read_port_select_n = 1'b1;
        lanes_n = 4'hf;
    end
    task idle(input int n);
        repeat (n)
        begin
            @(negedge clk);
            addr = 20'($urandom);
            wr_data = {4'($urandom), $urandom};
            lanes_n = 4'($urandom);
        end
    endtask : idle
    // Bit reversal kept the same for reads and writes; only bits 18:0
    // are reversed so wide mode, which ignores bit 19, loses nothing
    task do_write(input logic [19:0] a, input logic [35:0] d0, d1,
        input logic [3:0] l0, l1);
        @(negedge clk);
        write_port_select_n = 1'b0;
        addr = {a[19], {<<{a[18:0]}}};
        wr_data = d0;
        lanes_n = l0;
        @(negedge clk);
        write_port_select_n = 1'b1;
        addr = ~addr;
        wr_data = d1;
        lanes_n = l1;
        @(negedge clk);
        wr_data = ~d1;
        lanes_n = ~l1;
    endtask : do_write
    task do_read(input logic [19:0] a);
        @(negedge clk);
        read_port_select_n = 1'b0;
        addr = {a[19], {<<{a[18:0]}}};
        @(negedge clk);
        read_port_select_n = 1'b1;
        addr = ~addr;
    endtask : do_read
endmodule : mem_ctrl_model

// File: test_sync_sram_write_port_capture.sv
// Purpose: Self-checking bench for the capture block
// Assumes: Reads are spaced so each burst ends before the next
// Notes: Narrow-mode reads compare only lanes 0 and 1
`timescale 1ns/100ps
`include "sram_capture_regs.svh"
module test_sync_sram_write_port_capture;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic narrow_mode = 1'b0;
    logic [`ADDR_W_NARROW-1:0] addr;
    logic [`DATA_W-1:0] wr_data, rd_data;
    logic wps_n, rps_n, rd_data_oe, wr_commit;
    logic [3:0] lanes_n;
    logic [35:0] mem [int];
    int fail_count = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    mem_ctrl_model i_ctrl (.clk(clk), .addr(addr), .wr_data(wr_data),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n),
        .lanes_n(lanes_n));
    sync_sram_write_port_capture i_dut (.clk(clk), .rst_n(rst_n),
        .narrow_mode(narrow_mode), .addr(addr), .wr_data(wr_data),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n),
        .byte_lane0_write_n(lanes_n[0]), .byte_lane1_write_n(lanes_n[1]),
        .byte_lane2_write_n(lanes_n[2]), .byte_lane3_write_n(lanes_n[3]),
        .rd_data(rd_data), .rd_data_oe(rd_data_oe), .wr_commit(wr_commit));
    task check(input string what, input logic [35:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    // Lanes above 1 are out of reach in narrow mode
    task model_wr(input int k, input logic [35:0] d, input logic [3:0] ln);
        for (int g = 0; g < 4; g++)
            if (!ln[g] && (g < 2 || !narrow_mode))
                mem[k][9*g+:9] = d[9*g+:9];
    endtask : model_wr
    initial
    begin
        #20000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        logic [35:0] d0, d1, m;
        logic [3:0] l0, l1;
        int a;
        void'($urandom(34));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            a = (i < 8) ? i : $urandom_range(7);
            narrow_mode = (i >= 8) && (i % 5 == 0);
            i_ctrl.idle(2 + i % 3);
            d0 = {4'($urandom), $urandom};
            d1 = {4'($urandom), $urandom};
            l0 = (i < 8) ? 4'h0 : 4'($urandom);
            l1 = (i < 8) ? 4'h0 : 4'($urandom);
            i_ctrl.do_write(20'(a), d0, d1, l0, l1);
            model_wr(2 * a, d0, l0);
            model_wr(2 * a + 1, d1, l1);
            i_ctrl.do_read(20'(a));
            check("commit", {35'h0, wr_commit}, 36'h1);
            m = narrow_mode ? 36'h00003ffff : 36'hfffffffff;
            repeat (2) @(negedge clk);
            check("oe", {35'h0, rd_data_oe}, 36'h1);
            check("word0", rd_data & m, mem[2 * a] & m);
            @(negedge clk);
            check("word1", rd_data & m, mem[2 * a + 1] & m);
            @(negedge clk);
            check("oe_off", {35'h0, rd_data_oe}, 36'h0);
        end
        complete_run();
    end
endmodule : test_sync_sram_write_port_capture
